// >>> ecct_pkg.sv
// Package with constants, types and register map of the edge-cleared capture timer.
package ecct_pkg;
	localparam int CNT_W = 16;

	localparam logic [11:0] OFS_MODE_CTRL = 12'h000;
	localparam logic [11:0] OFS_PRESCALE  = 12'h004;
	localparam logic [11:0] OFS_CAPCMP_C  = 12'h008;
	localparam logic [11:0] OFS_OUT_CTRL  = 12'h00C;
	localparam logic [11:0] OFS_CAPCMP_A  = 12'h010;
	localparam logic [11:0] OFS_CAPCMP_B  = 12'h014;
	localparam logic [11:0] OFS_COUNT     = 12'h018;

	// timer_mode_ctrl fields.
	localparam int MODE_POS       = 2;
	localparam int EDGE_TOGGLE_POS = 1;
	// prescale_sel fields.
	localparam int CLK_SEL_POS    = 0;
	localparam int PRI_EDGE_POS   = 4;
	localparam int SEC_EDGE_POS   = 6;
	// capcmp_ctrl fields.
	localparam int A_CAP_POS      = 0;
	localparam int REV_PHASE_POS  = 1;
	localparam int B_CAP_POS      = 2;
	// timer_out_ctrl fields.
	localparam int OUT_EN_POS     = 0;
	localparam int MATCH_TGL_POS  = 1;

	localparam logic [1:0]  MODE_STOP      = 2'b00;
	localparam logic [1:0]  MODE_EDGE_CLR  = 2'b10;
	localparam logic [1:0]  EDGE_FALL      = 2'b00;
	localparam logic [1:0]  EDGE_RISE      = 2'b01;
	localparam logic [1:0]  EDGE_NONE      = 2'b10;
	localparam logic [1:0]  EDGE_BOTH      = 2'b11;
	localparam logic [1:0]  CLK_PRI_EDGE   = 2'b11;

	localparam logic [7:0]  RST_CTRL       = 8'h00;
	localparam logic [15:0] RST_CNT        = 16'h0000;
	localparam logic [1:0]  RST_DIV        = 2'b00;

	// Prescaler divide ratios as shift amounts for the clock selects 01 and 10.
	localparam int DIV1_LOG = 2;
	localparam int DIV2_LOG = 4;
	localparam int PDIV_W   = 4;

	typedef enum logic [1:0] {
		CS_DIRECT = 2'b00,
		CS_DIV1   = 2'b01,
		CS_DIV2   = 2'b10,
		CS_EXT    = 2'b11
	} clk_sel_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} edge_pair_t;

	typedef struct packed {
		logic [1:0] mode;
		logic       edge_toggle_en;
		clk_sel_t   clk_sel;
		logic [1:0] pri_edge_sel;
		logic [1:0] sec_edge_sel;
		logic       a_cap;
		logic       rev_phase;
		logic       b_cap;
		logic       out_en;
		logic       match_tgl;
	} timer_cfg_t;
endpackage

// >>> ecct_edge_filter.sv
// Two-sample noise filter with one-clock rising and falling edge pulses.
`timescale 1ns/1ps
`default_nettype none
module ecct_edge_filter
	import ecct_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 pin,
	output ecct_pkg::edge_pair_t      edges
);
	logic samp1;
	logic samp2;
	logic level;

	// A new level is believed only after two equal consecutive samples.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp1 <= 1'b0;
			samp2 <= 1'b0;
			level <= 1'b0;
		end else begin
			samp1 <= pin;
			samp2 <= samp1;
			if (samp1 == samp2)
				level <= samp2;
		end
	end

	assign edges.rise = (samp1 == samp2) && samp2 && !level;
	assign edges.fall = (samp1 == samp2) && !samp2 && level;
endmodule
`default_nettype wire

// >>> ecct_prescaler.sv
// Count clock tick generator selected by the clock select field.
`timescale 1ns/1ps
`default_nettype none
module ecct_prescaler
	import ecct_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 run,
	input  wire ecct_pkg::clk_sel_t   clk_sel,
	input  wire logic                 ext_edge,
	output logic                      tick
);
	logic [PDIV_W-1:0] div;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div <= '0;
		else if (!run)
			div <= '0;
		else
			div <= div + 1'b1;
	end

	always_comb begin
		case (clk_sel)
			CS_DIRECT: tick = run;
			CS_DIV1:   tick = run && (div[DIV1_LOG-1:0] == '1);
			CS_DIV2:   tick = run && (div[DIV2_LOG-1:0] == '1);
			CS_EXT:    tick = run && ext_edge;
			default:   tick = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// >>> ecct_timer.sv
// Edge-cleared 16-bit capture/compare timer channel with an APB register file.
`timescale 1ns/1ps
`default_nettype none
module ecct_timer
	import ecct_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 primary_cap_in,
	input  wire logic                 secondary_cap_in,
	output logic                      event_a,
	output logic                      event_b,
	output logic                      toggle_out
);
	import ecct_pkg::*;

	logic [7:0]       timer_mode_ctrl;
	logic [7:0]       prescale_sel;
	logic [7:0]       capcmp_ctrl;
	logic [7:0]       timer_out_ctrl;
	logic [CNT_W-1:0] capcmp_a;
	logic [CNT_W-1:0] capcmp_b;
	logic [CNT_W-1:0] count_value;
	logic             count_moved;
	logic [1:0]       prev_mode;

	timer_cfg_t       cfg;
	edge_pair_t       pri_edges;
	edge_pair_t       sec_edges;
	logic             tick;
	logic             running;
	logic             edge_clear_mode;
	logic             pri_valid;
	logic             pri_reverse;
	logic             sec_valid;
	logic             match_a;
	logic             match_b;
	logic             cap_a;
	logic             cap_b;
	logic             wr_en;
	logic             setup;
	logic [11:0]      offs;
	logic             next_event_a;
	logic             next_event_b;
	logic             next_toggle;

	// Picks the edge pulse that a two-bit edge select calls valid.
	function automatic logic edge_hit(input logic [1:0] sel,
		input edge_pair_t e);
		case (sel)
			EDGE_FALL: edge_hit = e.fall;
			EDGE_RISE: edge_hit = e.rise;
			EDGE_BOTH: edge_hit = e.rise | e.fall;
			default:   edge_hit = 1'b0;
		endcase
	endfunction

	// Opposite phase only exists when a single edge is selected.
	function automatic logic edge_opposite(input logic [1:0] sel,
		input edge_pair_t e);
		case (sel)
			EDGE_FALL: edge_opposite = e.rise;
			EDGE_RISE: edge_opposite = e.fall;
			default:   edge_opposite = 1'b0;
		endcase
	endfunction

	function automatic logic is_offset(input logic [11:0] a,
		input logic [11:0] o);
		is_offset = (a == o);
	endfunction

	assign cfg.mode           = timer_mode_ctrl[MODE_POS+:2];
	assign cfg.edge_toggle_en = timer_mode_ctrl[EDGE_TOGGLE_POS];
	assign cfg.clk_sel        = clk_sel_t'(prescale_sel[CLK_SEL_POS+:2]);
	assign cfg.pri_edge_sel   = prescale_sel[PRI_EDGE_POS+:2];
	assign cfg.sec_edge_sel   = prescale_sel[SEC_EDGE_POS+:2];
	assign cfg.a_cap          = capcmp_ctrl[A_CAP_POS];
	assign cfg.rev_phase      = capcmp_ctrl[REV_PHASE_POS];
	assign cfg.b_cap          = capcmp_ctrl[B_CAP_POS];
	assign cfg.out_en         = timer_out_ctrl[OUT_EN_POS];
	assign cfg.match_tgl      = timer_out_ctrl[MATCH_TGL_POS];

	ecct_edge_filter u_pri_filter (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (primary_cap_in),
		.edges   (pri_edges)
	);

	ecct_edge_filter u_sec_filter (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (secondary_cap_in),
		.edges   (sec_edges)
	);

	// Selecting the primary edge as count clock in edge-clear mode keeps clearing the
	// counter; software is expected to avoid it.
	ecct_prescaler u_prescaler (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (running),
		.clk_sel  (cfg.clk_sel),
		.ext_edge (pri_valid),
		.tick     (tick)
	);

	assign running         = (cfg.mode != MODE_STOP);
	assign edge_clear_mode = (cfg.mode == MODE_EDGE_CLR);
	assign pri_valid   = running && edge_hit(cfg.pri_edge_sel, pri_edges);
	assign pri_reverse = running && edge_opposite(cfg.pri_edge_sel,
		pri_edges);
	assign sec_valid   = running && edge_hit(cfg.sec_edge_sel, sec_edges);

	// A match counts once, in the first clock the counter holds the value,
	// so a slow count clock still gives one event per match. The first
	// clock after mode entry counts as fresh, so zero matches there.
	assign match_a = running && !cfg.a_cap &&
		(count_moved || prev_mode == MODE_STOP) &&
		(count_value == capcmp_a);
	assign match_b = running && !cfg.b_cap &&
		(count_moved || prev_mode == MODE_STOP) &&
		(count_value == capcmp_b);

	// Register A captures on the opposite primary phase when that is
	// selected, else on secondary edges.
	assign cap_a = cfg.a_cap && (cfg.rev_phase ? pri_reverse : sec_valid);
	assign cap_b = cfg.b_cap && pri_valid;

	// Stop clears, a primary edge clears in edge-clear mode, otherwise a tick advances and the
	// plain increment wraps from all ones to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= RST_CNT;
			count_moved <= 1'b0;
		end else if (!running) begin
			count_value <= RST_CNT;
			count_moved <= 1'b0;
		end else if (edge_clear_mode && pri_valid) begin
			count_value <= RST_CNT;
			count_moved <= 1'b1;
		end else if (tick) begin
			count_value <= count_value + 1'b1;
			count_moved <= 1'b1;
		end else begin
			count_moved <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prev_mode <= MODE_STOP;
		else
			prev_mode <= cfg.mode;
	end

	// An opposite-phase capture stays silent; with A in capture mode, secondary
	// edges raise event A whether or not they latch.
	always_comb begin
		next_event_a = match_a || (cfg.a_cap && sec_valid);
		next_event_b = match_b || cap_b;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_a <= 1'b0;
			event_b <= 1'b0;
		end else begin
			event_a <= next_event_a;
			event_b <= next_event_b;
		end
	end

	// Match and edge in one clock give a single inversion.
	always_comb begin
		next_toggle = toggle_out;
		if (!cfg.out_en)
			next_toggle = 1'b0;
		else if ((cfg.match_tgl && (match_a || match_b)) ||
			(cfg.edge_toggle_en && edge_clear_mode && pri_valid))
			next_toggle = !toggle_out;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			toggle_out <= 1'b0;
		else
			toggle_out <= next_toggle;
	end

	assign offs  = paddr[11:0];
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_mode_ctrl <= RST_CTRL;
			prescale_sel    <= RST_CTRL;
			capcmp_ctrl     <= RST_CTRL;
			timer_out_ctrl  <= RST_CTRL;
		end else if (wr_en) begin
			if (is_offset(offs, OFS_MODE_CTRL))
				timer_mode_ctrl <= pwdata[7:0];
			if (is_offset(offs, OFS_PRESCALE))
				prescale_sel <= pwdata[7:0];
			if (is_offset(offs, OFS_CAPCMP_C))
				capcmp_ctrl <= pwdata[7:0];
			if (is_offset(offs, OFS_OUT_CTRL))
				timer_out_ctrl <= pwdata[7:0];
		end
	end

	// A capture in the same clock as a software write wins, so a measured
	// value is never lost to a stray write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			capcmp_a <= RST_CNT;
		else if (cap_a)
			capcmp_a <= count_value;
		else if (wr_en && is_offset(offs, OFS_CAPCMP_A))
			capcmp_a <= pwdata[CNT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			capcmp_b <= RST_CNT;
		else if (cap_b)
			capcmp_b <= count_value;
		else if (wr_en && is_offset(offs, OFS_CAPCMP_B))
			capcmp_b <= pwdata[CNT_W-1:0];
	end

	// Read data and the answer are prepared in the setup cycle so that every
	// bus output comes from a flip-flop with no wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (setup) begin
				case (offs)
					OFS_MODE_CTRL: prdata <= {24'h000000, timer_mode_ctrl};
					OFS_PRESCALE:  prdata <= {24'h000000, prescale_sel};
					OFS_CAPCMP_C:  prdata <= {24'h000000, capcmp_ctrl};
					OFS_OUT_CTRL:  prdata <= {24'h000000, timer_out_ctrl};
					OFS_CAPCMP_A:  prdata <= {16'h0000, capcmp_a};
					OFS_CAPCMP_B:  prdata <= {16'h0000, capcmp_b};
					OFS_COUNT:     prdata <= {16'h0000, count_value};
					default:       pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> ecct_timer_assertions.sv
// Port-level checker for the edge-cleared capture timer.
`timescale 1ns/1ps
`default_nettype none
module ecct_timer_assertions
	import ecct_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        primary_cap_in,
	input wire logic        secondary_cap_in,
	input wire logic        event_a,
	input wire logic        event_b,
	input wire logic        toggle_out
);
	logic [7:0] mc;
	logic [7:0] cc;
	logic [7:0] oc;
	logic [4:0] ph;
	logic [4:0] sh;
	logic       run;
	logic       stp;
	logic       pmv;
	logic       smv;
	assign run = mc[MODE_POS +: 2] == MODE_EDGE_CLR;
	assign stp = mc[MODE_POS +: 2] == MODE_STOP;
	// An input moved somewhere in the last two to five samples.
	assign pmv = ph[4:1] != 4'h0 && ph[4:1] != 4'hF;
	assign smv = sh[4:1] != 4'h0 && sh[4:1] != 4'hF;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mc <= 8'h00;
			cc <= 8'h00;
			oc <= 8'h00;
			ph <= 5'h00;
			sh <= 5'h00;
		end else begin
			ph <= {ph[3:0], primary_cap_in};
			sh <= {sh[3:0], secondary_cap_in};
			if (psel && penable && pready && pwrite) begin
				if (paddr[11:0] == OFS_MODE_CTRL) mc <= pwdata[7:0];
				if (paddr[11:0] == OFS_CAPCMP_C) cc <= pwdata[7:0];
				if (paddr[11:0] == OFS_OUT_CTRL) oc <= pwdata[7:0];
			end
		end
	end
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_evb_one: assert property (event_b |=> !event_b)
		else $error("event_b longer than a cycle");
	chk_eva_one: assert property (event_a |=> !event_a)
		else $error("event_a longer than a cycle");
	chk_evb_cause: assert property (event_b && cc[B_CAP_POS] && run |-> pmv)
		else $error("capture event without primary edge");
	chk_noise_drop: assert property ($rose(primary_cap_in) ##1
		$fell(primary_cap_in) && cc[B_CAP_POS] && run |=> !event_b [*5])
		else $error("primary glitch accepted");
	chk_eva_sec: assert property (event_a && run && cc[A_CAP_POS]
		&& cc[REV_PHASE_POS] |-> smv)
		else $error("event_a without secondary edge");
	chk_stop_quiet: assert property (stp && $past(stp)
		|-> !event_a && !event_b)
		else $error("event while stopped");
	chk_tgl_hold: assert property (!oc[MATCH_TGL_POS] &&
		!mc[EDGE_TOGGLE_POS] && oc == $past(oc, 2) && mc == $past(mc, 2)
		|-> $stable(toggle_out))
		else $error("toggle_out moved with toggling off");
	chk_evb_tgl: assert property (event_b && cc[B_CAP_POS] && run
		&& mc[EDGE_TOGGLE_POS] && oc[OUT_EN_POS] |-> ##[0:1] $changed(toggle_out))
		else $error("toggle_out kept on primary edge");
	cover property (event_b && cc[B_CAP_POS]);
	cover property (event_a && cc[REV_PHASE_POS]);
	cover property ($changed(toggle_out));
endmodule
`default_nettype wire

// >>> ecct_pulse_src.sv
// Behavioural pulse source driving both capture inputs.
`timescale 1ns/1ps
`default_nettype none
module ecct_pulse_src (
	input  wire logic pclk,
	output var logic  pri,
	output var logic  sec
);
	initial begin
		pri = 1'b0;
		sec = 1'b0;
	end
	// Levels stand a whole number of clocks; a hold of one is noise.
	task automatic drive(input logic p, input logic s, input int hold);
		pri <= p;
		sec <= s;
		repeat (hold) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// >>> tb_ecct_timer.sv
// Self-checking bench for the edge-cleared capture timer.
`timescale 1ns/1ps
`default_nettype none
module tb_ecct_timer;
	import ecct_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pri, sec, event_a, event_b, toggle_out, tq, err;
	logic [31:0] paddr, pwdata, prdata, q, q0;
	int          miscompares, cmp_count, eva_n, evb_n, tg_n, cyc;
	ecct_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.primary_cap_in(pri), .secondary_cap_in(sec), .event_a(event_a),
		.event_b(event_b), .toggle_out(toggle_out));
	ecct_pulse_src src_u (.pclk(pclk), .pri(pri), .sec(sec));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Tallies expose stretched pulses and missing or extra inversions.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		tq <= toggle_out;
		if (event_a === 1'b1) eva_n <= eva_n + 1;
		if (event_b === 1'b1) evb_n <= evb_n + 1;
		if (presetn && toggle_out !== tq) tg_n <= tg_n + 1;
		if (cyc == 70000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h00000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) miscompares++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic clr();
		eva_n = 0;
		evb_n = 0;
		tg_n = 0;
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd("mode", OFS_MODE_CTRL, 32'h0);
		rd("count", OFS_COUNT, 32'h0);
		wr(OFS_CAPCMP_A, 32'hFFFF_FFFF);
		rd("a_width", OFS_CAPCMP_A, 32'h0000_FFFF);
		wr(12'h01C, 32'h5);
		chk("wr_err", {31'h0, err}, 32'h1);
		rd("unmapped", 12'h01C, 32'h0);
		chk("rd_err", {31'h0, err}, 32'h1);
		$display("test map done");
		wr(OFS_PRESCALE, 32'h90);
		wr(OFS_CAPCMP_A, 32'h1234);
		wr(OFS_CAPCMP_B, 32'h4321);
		wr(OFS_OUT_CTRL, 32'h3);
		clr();
		wr(OFS_MODE_CTRL, 32'h8);
		apb(1'b0, OFS_COUNT, 32'h0);
		q0 = q;
		apb(1'b0, OFS_COUNT, 32'h0);
		chk("step", q - q0, 32'h3);
		q0 = q;
		// Reads sit exactly one full counter period apart.
		repeat (65533) @(posedge pclk);
		rd("wrap", OFS_COUNT, q0);
		chk("match_a", eva_n, 32'h1);
		chk("match_b", evb_n, 32'h1);
		chk("match_tgl", tg_n, 32'h2);
		wr(OFS_MODE_CTRL, 32'h0);
		rd("stopped", OFS_COUNT, 32'h0);
		$display("test count done");
		wr(OFS_PRESCALE, 32'hB0);
		wr(OFS_CAPCMP_C, 32'h4);
		wr(OFS_CAPCMP_A, 32'h0);
		clr();
		wr(OFS_MODE_CTRL, 32'hA);
		src_u.drive(1'b1, 1'b0, 10);
		src_u.drive(1'b0, 1'b0, 20);
		chk("cap_ev", evb_n, 32'h2);
		chk("zero_ev", eva_n, 32'h3);
		chk("toggles", tg_n, 32'h5);
		rd("cap_b", OFS_CAPCMP_B, 32'h9);
		wr(OFS_MODE_CTRL, 32'h0);
		$display("test clear done");
		wr(OFS_PRESCALE, 32'h40);
		wr(OFS_CAPCMP_C, 32'h7);
		wr(OFS_OUT_CTRL, 32'h1);
		clr();
		wr(OFS_MODE_CTRL, 32'h8);
		src_u.drive(1'b1, 1'b0, 12);
		src_u.drive(1'b0, 1'b0, 20);
		src_u.drive(1'b1, 1'b0, 12);
		src_u.drive(1'b0, 1'b0, 8);
		src_u.drive(1'b1, 1'b0, 1);
		src_u.drive(1'b0, 1'b0, 8);
		src_u.drive(1'b0, 1'b1, 6);
		src_u.drive(1'b0, 1'b0, 6);
		rd("low_w", OFS_CAPCMP_A, 32'd19);
		rd("period", OFS_CAPCMP_B, 32'd31);
		chk("sec_ev", eva_n, 32'h1);
		chk("glitch", evb_n, 32'h2);
		chk("quiet", tg_n, 32'h0);
		$display("test width done");
		complete_run();
	end
endmodule
bind ecct_timer ecct_timer_assertions chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .primary_cap_in(primary_cap_in),
	.secondary_cap_in(secondary_cap_in), .event_a(event_a),
	.event_b(event_b), .toggle_out(toggle_out));
`default_nettype wire
